// ---- hdl/sensor_cfg_map.vh ----
// Register map, field layout, reset values and timing of the config bank
`ifndef SENSOR_CFG_MAP_VH
`define SENSOR_CFG_MAP_VH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define ADDR_HALL_SPIN_CONFIG   8'h11
`define ADDR_HALL_BIAS_LEVEL    8'h12
`define ADDR_FILTER_SELECT      8'h14
`define ADDR_OSC_TRIM           8'h15
`define ADDR_OSC_TEMP_COMP      8'h16
`define ADDR_OTP_VALIDITY_FLAGS 8'h20

// ------------------------------------------------------------------
// Reset values and writable masks
// ------------------------------------------------------------------
`define RST_HALL_SPIN_CONFIG    8'h11
`define RST_HALL_BIAS_LEVEL     8'h70
`define RST_FILTER_SELECT       8'h01
`define RST_OSC_TRIM            8'h80
`define RST_OSC_TEMP_COMP       8'h00
`define MASK_HALL_SPIN_CONFIG   8'h3f
`define MASK_FILTER_SELECT      8'h7f

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define F_SPIN_PERIOD           1:0
`define F_BLANKING              3:2
`define B_MASK_OFF              4
`define B_TWO_PHASE             5
`define F_LP_CORNER             1:0
`define B_HALL_LP160            2
`define B_COIL_OFF              3
`define B_COIL_HP_BYPASS        4
`define F_HP_SEL                6:5
`define F_TC_LOW                3:0
`define F_TC_HIGH               7:4
`define B_ST_FACT_VALID         0
`define B_ST_FACT_SUM           1
`define B_ST_USER_FOUND         2
`define B_ST_USER_SUM           3
`define B_ST_TEMP               4

// ------------------------------------------------------------------
// Timing, in ns, with the clock period
// ------------------------------------------------------------------
`define CLK_NS                  40
`define SPIN_STEP_NS            200
`define BLANK_STEP_NS           50
`define MASK_NS                 50

// ------------------------------------------------------------------
// Temperature thresholds in degrees C
// ------------------------------------------------------------------
`define THR_20C                 8'h14
`define THR_40C                 8'h28
`define THR_60C                 8'h3c
`define THR_80C                 8'h50

// ------------------------------------------------------------------
// OTP layout
// ------------------------------------------------------------------
`define OTP_PAGE_MUL            128
`define OTP_BYTE_MUL            8
`define OTP_MARKER              8'ha5
`define OTP_MARKER_BYTE         4'h9
`define OTP_LAST_BYTE           4'ha
`define OTP_TRIM_BYTE           4'h0
`define OTP_TC_BYTE             4'h1
`define OTP_FACTORY_PAGE        3'h4
`define OTP_LAST_USER_PAGE      3'h3

`endif

// ---- hdl/sensor_config_otp_status.v ----
// Configuration registers, Hall spin timing and OTP status of the sensor
//
// Behaviour
// R1: Spin period 200..800 ns, reset 01
// R2: Rectifier blanking 50..200 ns, reset 00
// R3: Mask bit 0 masks two clocks per cycle
// R4: Phase bit selects four or two phases
// R5: Low-pass corner 5/10/20 kHz, reset 01
// R6: Bit enables extra 160 kHz Hall low-pass
// R7: Bit disables coil path, reset active
// R8: Bit bypasses coil high-pass filter
// R9: High-pass select scales with low-pass choice
// R10: Trim oscillator to 20 MHz, reset 0x80
// R11: Low nibble compensates below threshold, signed
// R12: High nibble compensates above threshold, reset 0
// R13: Status at 0x20, four OTP flags
// R14: OTP flags once; temperature flag continuous
// R15: Temperature flag set above selected threshold
// R16: OTP bit address page*128+byte*8+bit
// R17: Page accepted on marker 0xa5 and checksum
// R18: All data-set bytes sum to zero
// R19: Threshold 20/40/60/80 C also splits segments
// R20: No valid page keeps defaults, flags clear; the factory marker or sum flag is still set when its own check alone passes
// R21: Status writes ignored; reserved bits read zero
`timescale 1ns/1ps
`include "sensor_cfg_map.vh"

module sensor_config_otp_status #(
	parameter ADDR_W = 8,
	parameter OTP_W  = 10
) (
	input  wire              i_mclk,
	input  wire              i_rst_n,
	input  wire [ADDR_W-1:0] i_addr,
	input  wire [7:0]        i_wdata,
	input  wire              i_wr,
	input  wire              i_rd,
	output reg  [7:0]        o_rdata,
	output reg               o_rvalid,
	input  wire [7:0]        i_temp_c,
	input  wire [2:0]        i_thr_sel,
	output reg               o_otp_rd,
	output reg  [OTP_W-1:0]  o_otp_addr,
	input  wire [7:0]        i_otp_data,
	output reg               o_load_done,
	output reg  [1:0]        o_spin_phase,
	output reg               o_blank,
	output reg               o_mask,
	output reg  [7:0]        o_bias,
	output reg  [1:0]        o_lp_sel,
	output reg               o_hall_lp160,
	output reg               o_coil_off,
	output reg               o_coil_hp_bypass,
	output reg  [1:0]        o_hp_sel,
	output reg  [7:0]        o_osc_trim,
	output reg               o_tc_neg,
	output reg  [2:0]        o_tc_step,
	output reg               o_temp_above
);

	// Timing constants held at the width of the nanosecond arithmetic
	localparam [9:0] CLK_NS_W     = `CLK_NS;
	localparam [9:0] CLK_RND_W    = `CLK_NS - 1;
	localparam [9:0] SPIN_STEP_W  = `SPIN_STEP_NS;
	localparam [9:0] BLANK_STEP_W = `BLANK_STEP_NS;
	localparam [9:0] MASK_W       = `MASK_NS;

	// Rounds a duration up to whole clocks, so no phase runs short
	function [4:0] ceil_cyc;
		input [9:0] ns;
		reg   [9:0] cyc;
		begin
			cyc      = (ns + CLK_RND_W) / CLK_NS_W;
			ceil_cyc = cyc[4:0];
		end
	endfunction

	localparam [2:0] S_RD   = 3'h1;
	localparam [2:0] S_WT   = 3'h2;
	localparam [2:0] S_DONE = 3'h4;

	reg  [7:0] spin_cfg_q;
	reg  [7:0] filt_q;
	reg  [7:0] tc_q;
	reg  [3:0] stat_q;
	reg  [2:0] st_q;
	reg  [2:0] page_q;
	reg  [3:0] byte_q;
	reg  [7:0] sum_q;
	reg        mark_ok_q;
	reg  [7:0] ld_trim_q;
	reg  [7:0] ld_tc_q;
	reg  [4:0] spin_cnt_q;
	reg  [4:0] blank_cnt_q;
	reg  [4:0] mask_cnt_q;
	reg  [4:0] spin_cnt_d;
	reg  [4:0] blank_cnt_d;
	reg  [4:0] mask_cnt_d;
	reg  [1:0] phase_d;
	reg  [7:0] thr;
	reg  [7:0] rd_mux;
	wire [7:0] sum_next;
	wire       set_ok;
	wire       last_byte;
	wire [9:0] spin_ns;
	wire [9:0] blank_ns;

	// Full-width bit address, cut to the port width when registered
	reg [31:0] otp_bit_addr;

	// ------------------------------------------------------------------
	// Hall spinning sequencer
	// ------------------------------------------------------------------
	assign spin_ns  = ({8'h00, spin_cfg_q[`F_SPIN_PERIOD]} + 10'h001) *
		SPIN_STEP_W;
	assign blank_ns = ({8'h00, spin_cfg_q[`F_BLANKING]} + 10'h001) *
		BLANK_STEP_W;

	always @* begin
		spin_cnt_d  = spin_cnt_q - 5'h01;
		phase_d     = o_spin_phase;
		blank_cnt_d = (blank_cnt_q != 5'h00) ? blank_cnt_q - 5'h01 : 5'h00;
		mask_cnt_d  = (mask_cnt_q != 5'h00) ? mask_cnt_q - 5'h01 : 5'h00;
		if (spin_cnt_q <= 5'h01) begin
			// R1: period per code
			spin_cnt_d = ceil_cyc(spin_ns);
			// R4: two or four phases
			if (spin_cfg_q[`B_TWO_PHASE])
				phase_d = {1'b0, ~o_spin_phase[0]};
			else
				phase_d = o_spin_phase + 2'h1;
			// R2: blanking after each phase switch
			blank_cnt_d = ceil_cyc(blank_ns);
			// R3: mask only when bit is low
			mask_cnt_d = spin_cfg_q[`B_MASK_OFF] ? 5'h00 :
				ceil_cyc(MASK_W);
		end
	end

	// ------------------------------------------------------------------
	// Temperature threshold and compensation segment
	// ------------------------------------------------------------------
	always @* begin
		// R19: codes above 3 hold the top threshold
		case (i_thr_sel)
			3'h0:    thr = `THR_20C;
			3'h1:    thr = `THR_40C;
			3'h2:    thr = `THR_60C;
			default: thr = `THR_80C;
		endcase
	end

	// ------------------------------------------------------------------
	// Register read mux
	// ------------------------------------------------------------------
	always @* begin
		case (i_addr)
			`ADDR_HALL_SPIN_CONFIG:   rd_mux = spin_cfg_q;
			`ADDR_HALL_BIAS_LEVEL:    rd_mux = o_bias;
			`ADDR_FILTER_SELECT:      rd_mux = filt_q;
			`ADDR_OSC_TRIM:           rd_mux = o_osc_trim;
			`ADDR_OSC_TEMP_COMP:      rd_mux = tc_q;
			// R13: flags in low bits, reserved read zero
			`ADDR_OTP_VALIDITY_FLAGS: rd_mux = {3'h0, o_temp_above, stat_q};
			default:                  rd_mux = 8'h00;
		endcase
	end

	// ------------------------------------------------------------------
	// OTP scan arithmetic
	// ------------------------------------------------------------------
	// R16: page and byte weights, bit 0 of the byte
	always @* begin
		otp_bit_addr = page_q * `OTP_PAGE_MUL + byte_q * `OTP_BYTE_MUL;
	end

	// R18: running byte sum modulo 256
	assign sum_next  = sum_q + i_otp_data;
	assign last_byte = (byte_q == `OTP_LAST_BYTE);
	// R17: marker and zero sum
	assign set_ok    = mark_ok_q && (sum_next == 8'h00);

	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			spin_cfg_q       <= `RST_HALL_SPIN_CONFIG;
			filt_q           <= `RST_FILTER_SELECT;
			tc_q             <= `RST_OSC_TEMP_COMP;
			o_bias           <= `RST_HALL_BIAS_LEVEL;
			o_osc_trim       <= `RST_OSC_TRIM;
			stat_q           <= 4'h0;
			st_q             <= S_RD;
			page_q           <= `OTP_FACTORY_PAGE;
			byte_q           <= 4'h0;
			sum_q            <= 8'h00;
			mark_ok_q        <= 1'b0;
			ld_trim_q        <= 8'h00;
			ld_tc_q          <= 8'h00;
			spin_cnt_q       <= 5'h00;
			blank_cnt_q      <= 5'h00;
			mask_cnt_q       <= 5'h00;
			o_rdata          <= 8'h00;
			o_rvalid         <= 1'b0;
			o_otp_rd         <= 1'b0;
			o_otp_addr       <= {OTP_W{1'b0}};
			o_load_done      <= 1'b0;
			o_spin_phase     <= 2'h0;
			o_blank          <= 1'b0;
			o_mask           <= 1'b0;
			o_lp_sel         <= 2'h1;
			o_hall_lp160     <= 1'b0;
			o_coil_off       <= 1'b0;
			o_coil_hp_bypass <= 1'b0;
			o_hp_sel         <= 2'h0;
			o_tc_neg         <= 1'b0;
			o_tc_step        <= 3'h0;
			o_temp_above     <= 1'b0;
		end else begin
			spin_cnt_q   <= spin_cnt_d;
			blank_cnt_q  <= blank_cnt_d;
			mask_cnt_q   <= mask_cnt_d;
			o_spin_phase <= phase_d;
			o_blank      <= (blank_cnt_d != 5'h00);
			o_mask       <= (mask_cnt_d != 5'h00);
			o_rvalid     <= i_rd;
			o_rdata      <= i_rd ? rd_mux : 8'h00;
			// R14: temperature flag refreshed every cycle
			// R15: signed compare against threshold
			o_temp_above <= ($signed(i_temp_c) > $signed(thr));
			// R11: low nibble below the threshold
			// R12: high nibble above the threshold
			if (o_temp_above) begin
				{o_tc_neg, o_tc_step} <= tc_q[`F_TC_HIGH];
			end else begin
				{o_tc_neg, o_tc_step} <= tc_q[`F_TC_LOW];
			end
			// R5: low-pass corner
			o_lp_sel         <= filt_q[`F_LP_CORNER];
			// R6: extra Hall low-pass
			o_hall_lp160     <= filt_q[`B_HALL_LP160];
			// R7: coil path off
			o_coil_off       <= filt_q[`B_COIL_OFF];
			// R8: coil high-pass bypass
			o_coil_hp_bypass <= filt_q[`B_COIL_HP_BYPASS];
			// R9: high-pass scale code
			o_hp_sel         <= filt_q[`F_HP_SEL];
			// R21: status offset takes no write; unused bits masked
			if (i_wr) begin
				case (i_addr)
					`ADDR_HALL_SPIN_CONFIG:
						spin_cfg_q <= i_wdata & `MASK_HALL_SPIN_CONFIG;
					`ADDR_HALL_BIAS_LEVEL: o_bias <= i_wdata;
					`ADDR_FILTER_SELECT:
						filt_q <= i_wdata & `MASK_FILTER_SELECT;
					// R10: trim written by calibration
					`ADDR_OSC_TRIM:      o_osc_trim <= i_wdata;
					`ADDR_OSC_TEMP_COMP: tc_q <= i_wdata;
					default: ;
				endcase
			end
			o_otp_rd <= 1'b0;
			case (st_q)
				S_RD: begin
					o_otp_rd   <= 1'b1;
					// Wider sum cut to the port on purpose
					o_otp_addr <= otp_bit_addr[OTP_W-1:0];
					st_q       <= S_WT;
				end
				S_WT: begin
					sum_q <= sum_next;
					if (byte_q == `OTP_MARKER_BYTE)
						mark_ok_q <= (i_otp_data == `OTP_MARKER);
					if (byte_q == `OTP_TRIM_BYTE)
						ld_trim_q <= i_otp_data;
					if (byte_q == `OTP_TC_BYTE)
						ld_tc_q <= i_otp_data;
					st_q   <= S_RD;
					byte_q <= byte_q + 4'h1;
					if (last_byte) begin
						byte_q    <= 4'h0;
						sum_q     <= 8'h00;
						mark_ok_q <= 1'b0;
						if (page_q == `OTP_FACTORY_PAGE) begin
							// R14: flags captured once after power-on
							stat_q[`B_ST_FACT_VALID] <= mark_ok_q;
							stat_q[`B_ST_FACT_SUM]   <= (sum_next == 8'h00);
							// R20: bad set leaves reset values
							if (set_ok) begin
								o_osc_trim <= ld_trim_q;
								tc_q       <= ld_tc_q;
							end
							page_q <= 3'h0;
						end else if (set_ok) begin
							stat_q[`B_ST_USER_FOUND] <= 1'b1;
							stat_q[`B_ST_USER_SUM]   <= 1'b1;
							st_q <= S_DONE;
						end else if (page_q == `OTP_LAST_USER_PAGE) begin
							st_q <= S_DONE;
						end else begin
							page_q <= page_q + 3'h1;
						end
					end
				end
				S_DONE: o_load_done <= 1'b1;
				default: st_q <= S_DONE;
			endcase
		end
	end

endmodule

// ---- verif/sensor_cfg_properties.sv ----
// Assertion checker for the sensor configuration bank
`timescale 1ns/1ps
module sensor_cfg_properties #(
	parameter ADDR_W = 8,
	parameter OTP_W  = 10
) (
	input wire              i_mclk,
	input wire              i_rst_n,
	input wire [ADDR_W-1:0] i_addr,
	input wire              i_rd,
	input wire [7:0]        o_rdata,
	input wire              o_rvalid,
	input wire [7:0]        i_temp_c,
	input wire [2:0]        i_thr_sel,
	input wire              o_otp_rd,
	input wire [OTP_W-1:0]  o_otp_addr,
	input wire              o_load_done,
	input wire [1:0]        o_spin_phase,
	input wire              o_blank,
	input wire              o_mask,
	input wire              o_temp_above
);
	// Codes above 3 saturate at the highest point
	function automatic [7:0] thr(input [2:0] s);
		thr = (s > 3'h3) ? 8'h50 : 8'h14 * {5'h0, s} + 8'h14;
	endfunction

	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	read_answer_a: assert property (i_rd |=> o_rvalid)
		else $error("read strobe got no answer");
	idle_bus_a: assert property (!i_rd |=> !o_rvalid && o_rdata == 8'h00)
		else $error("read data shown without a read");
	status_bits_a: assert property (i_rd && i_addr == 8'h20 |=>
		o_rdata[7:5] == 3'h0 && o_rdata[4] == $past(o_temp_above))
		else $error("status reserved or temperature bit wrong");
	temp_flag_a: assert property ($past(i_rst_n) |-> o_temp_above ==
		($signed($past(i_temp_c)) > $signed(thr($past(i_thr_sel)))))
		else $error("temperature flag does not follow threshold");
	blank_len_a: assert property ($rose(o_blank) |=> o_blank ##[1:4] !o_blank)
		else $error("blanking length out of range");
	mask_len_a: assert property ($rose(o_mask) |=> o_mask ##1 !o_mask)
		else $error("mask not two cycles");
	phase_hold_a: assert property ($changed(o_spin_phase) |=>
		$stable(o_spin_phase)[*4])
		else $error("spin phase shorter than five cycles");
	otp_addr_a: assert property (o_otp_rd |-> o_otp_addr[2:0] == 3'h0 &&
		o_otp_addr[6:3] <= 4'ha)
		else $error("otp address off byte grid");
	otp_space_a: assert property (o_otp_rd |=> !o_otp_rd)
		else $error("otp requests back to back");
	load_once_a: assert property (o_load_done |=> o_load_done && !o_otp_rd)
		else $error("otp read after load finished");
endmodule

bind sensor_config_otp_status sensor_cfg_properties #(
	.ADDR_W(ADDR_W),
	.OTP_W (OTP_W)
) u_props (
	.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_rd(i_rd),
	.o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_temp_c(i_temp_c),
	.i_thr_sel(i_thr_sel), .o_otp_rd(o_otp_rd), .o_otp_addr(o_otp_addr),
	.o_load_done(o_load_done), .o_spin_phase(o_spin_phase),
	.o_blank(o_blank), .o_mask(o_mask), .o_temp_above(o_temp_above)
);

// ---- verif/testbench.sv ----
// Self-checking bench for the sensor configuration bank
`timescale 1ns/1ps
`include "sensor_cfg_map.vh"
module testbench;
	reg        i_mclk, i_rst_n, i_wr, i_rd;
	reg  [7:0] i_addr, i_wdata, i_temp_c;
	reg  [2:0] i_thr_sel;
	reg  [7:0] i_otp_data = 8'h00;
	wire [7:0] o_rdata, o_bias, o_osc_trim;
	wire [9:0] o_otp_addr;
	wire [2:0] o_tc_step;
	wire [1:0] o_spin_phase, o_lp_sel, o_hp_sel;
	wire       o_rvalid, o_otp_rd, o_load_done, o_blank, o_mask, o_hall_lp160;
	wire       o_coil_off, o_coil_hp_bypass, o_tc_neg, o_temp_above;
	reg  [7:0] otp [0:79];
	reg  [7:0] rv, tv;
	reg  [1:0] c;
	integer    error_cnt, num_checks, n;

	sensor_config_otp_status u_sensor_config_otp_status (
		.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_rvalid(o_rvalid), .i_temp_c(i_temp_c), .i_thr_sel(i_thr_sel),
		.o_otp_rd(o_otp_rd), .o_otp_addr(o_otp_addr),
		.i_otp_data(i_otp_data), .o_load_done(o_load_done),
		.o_spin_phase(o_spin_phase), .o_blank(o_blank), .o_mask(o_mask),
		.o_bias(o_bias), .o_lp_sel(o_lp_sel), .o_hall_lp160(o_hall_lp160),
		.o_coil_off(o_coil_off), .o_coil_hp_bypass(o_coil_hp_bypass),
		.o_hp_sel(o_hp_sel), .o_osc_trim(o_osc_trim), .o_tc_neg(o_tc_neg),
		.o_tc_step(o_tc_step), .o_temp_above(o_temp_above)
	);

	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end

	// OTP byte only valid in the cycle after a request; garbage otherwise
	always @(negedge i_mclk)
		i_otp_data <= o_otp_rd ? otp[o_otp_addr[9:3]] : ~i_otp_data;

	task chk(input string nm, input [7:0] e, input [7:0] g);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("MISMATCH %0s exp %h got %h", nm, e, g);
			end
		end
	endtask

	task wr(input [7:0] a, input [7:0] d);
		begin
			@(negedge i_mclk);
			i_addr = a;
			i_wdata = d;
			i_wr = 1'b1;
			@(negedge i_mclk);
			i_wr = 1'b0;
		end
	endtask

	task rc(input [7:0] a, input [7:0] e);
		begin
			@(negedge i_mclk);
			i_addr = a;
			i_rd = 1'b1;
			@(negedge i_mclk);
			rv = (o_rvalid === 1'b1) ? o_rdata : 8'hxx;
			i_rd = 1'b0;
			chk($sformatf("reg %h", a), e, rv);
		end
	endtask

	// Data set with a two's complement checksum in the last byte
	task page(input [2:0] p, input [7:0] mk, input [7:0] b0, input [7:0] b1);
		integer k;
		reg [7:0] s;
		begin
			s = 8'h00;
			for (k = 0; k < 10; k = k + 1) begin
				otp[p*16+k] = (k == 9) ? mk : (k == 0) ? b0 :
					(k == 1) ? b1 : 8'h11 * k[7:0];
				s = s + otp[p*16+k];
			end
			otp[p*16+10] = 8'h00 - s;
		end
	endtask

	task rst_load;
		begin
			@(negedge i_mclk);
			i_rst_n = 1'b0;
			repeat (8) @(negedge i_mclk);
			i_rst_n = 1'b1;
		end
	endtask

	task wait_load;
		begin
			for (n = 0; n < 400 && o_load_done !== 1'b1; n = n + 1)
				@(negedge i_mclk);
			if (n == 400) begin
				$display("MISMATCH load_done exp 1 got %b", o_load_done);
				error_cnt = error_cnt + 1;
				report_and_stop;
			end
		end
	endtask

	task t_defaults;
		begin
			rc(`ADDR_HALL_SPIN_CONFIG, 8'h11);
			rc(`ADDR_HALL_BIAS_LEVEL, 8'h70);
			rc(`ADDR_FILTER_SELECT, 8'h01);
			rc(`ADDR_OSC_TRIM, 8'h80);
			rc(`ADDR_OSC_TEMP_COMP, 8'h00);
			rc(8'h13, 8'h00);
			$display("test defaults done");
		end
	endtask

	task t_load(input [7:0] fl, input [7:0] tr, input [7:0] tc);
		begin
			wait_load;
			rc(`ADDR_OTP_VALIDITY_FLAGS, fl);
			rc(`ADDR_OSC_TRIM, tr);
			rc(`ADDR_OSC_TEMP_COMP, tc);
			chk("osc_trim", tr, o_osc_trim);
			$display("test load done");
		end
	endtask

	task wf(input [7:0] d);
		begin
			wr(`ADDR_FILTER_SELECT, d);
			rc(`ADDR_FILTER_SELECT, d & 8'h7f);
			chk("filter", d & 8'h7f, {1'b0, o_hp_sel, o_coil_hp_bypass,
				o_coil_off, o_hall_lp160, o_lp_sel});
		end
	endtask

	task t_write;
		begin
			wr(`ADDR_HALL_SPIN_CONFIG, 8'hff);
			rc(`ADDR_HALL_SPIN_CONFIG, 8'h3f);
			wf(8'hff);
			wf(8'h2a);
			wr(`ADDR_OTP_VALIDITY_FLAGS, 8'h00);
			rc(`ADDR_OTP_VALIDITY_FLAGS, 8'h0f);
			wr(`ADDR_HALL_BIAS_LEVEL, 8'h5a);
			rc(`ADDR_HALL_BIAS_LEVEL, 8'h5a);
			chk("bias", 8'h5a, o_bias);
			wr(`ADDR_OSC_TRIM, 8'h37);
			chk("osc_trim", 8'h37, o_osc_trim);
			wr(`ADDR_OSC_TEMP_COMP, 8'hc3);
			rc(`ADDR_OSC_TEMP_COMP, 8'hc3);
			wr(8'h30, 8'hff);
			rc(8'h30, 8'h00);
			$display("test write done");
		end
	endtask

	// A 120-cycle window holds a whole number of every period
	task spin(input [7:0] cfg);
		integer k, ch, bl, mk;
		reg [1:0] ph, top;
		begin
			wr(`ADDR_HALL_SPIN_CONFIG, cfg);
			repeat (30) @(negedge i_mclk);
			ch = 0;
			bl = 0;
			mk = 0;
			top = 2'h0;
			ph = o_spin_phase;
			for (k = 0; k < 120; k = k + 1) begin
				@(negedge i_mclk);
				if (o_spin_phase !== ph)
					ch = ch + 1;
				ph = o_spin_phase;
				bl = bl + o_blank;
				mk = mk + o_mask;
				if (o_spin_phase > top)
					top = o_spin_phase;
			end
			k = 24 / (cfg[1:0] + 32'd1);
			chk("changes", k[7:0], ch[7:0]);
			chk("blank", 8'(k * (cfg[3:2] + 32'd2)), bl[7:0]);
			chk("mask", cfg[4] ? 8'h00 : 8'(2 * k), mk[7:0]);
			chk("top", cfg[5] ? 8'h01 : 8'h03, {6'h0, top});
		end
	endtask

	task temp(input [2:0] s, input [7:0] t, input e);
		begin
			@(negedge i_mclk);
			i_thr_sel = s;
			i_temp_c = t;
			repeat (3) @(negedge i_mclk);
			chk("above", {7'h0, e}, {7'h0, o_temp_above});
			chk("tc", e ? 8'h0c : 8'h03, {4'h0, o_tc_neg, o_tc_step});
			rc(`ADDR_OTP_VALIDITY_FLAGS, {3'h0, e, 4'hf});
		end
	endtask

	task report_and_stop;
		begin
			$display("checks %0d mismatches %0d", num_checks, error_cnt);
			if (error_cnt == 0 && num_checks > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask

	initial begin
		{i_rst_n, i_wr, i_rd, i_addr, i_wdata, i_temp_c, i_thr_sel} = 0;
		error_cnt = 0;
		num_checks = 0;
		page(3'h4, `OTP_MARKER, 8'h9c, 8'h3a);
		page(3'h0, 8'h5a, 8'h01, 8'h02);
		page(3'h1, `OTP_MARKER, 8'h03, 8'h04);
		otp[26] = otp[26] + 8'h01;
		page(3'h2, `OTP_MARKER, 8'h05, 8'h06);
		page(3'h3, `OTP_MARKER, 8'h07, 8'h08);
		rst_load;
		t_defaults;
		t_load(8'h0f, 8'h9c, 8'h3a);
		t_write;
		for (n = 0; n < 4; n = n + 1) begin
			c = n[1:0];
			spin(8'h10 + {4'h0, c, c});
		end
		spin(8'h05);
		spin(8'h35);
		$display("test spin done");
		for (n = 0; n < 8; n = n + 1) begin
			tv = (n > 3) ? 8'h50 : 8'h14 * n[7:0] + 8'h14;
			temp(n[2:0], tv + 8'h01, 1'b1);
			temp(n[2:0], tv, 1'b0);
		end
		temp(3'h0, 8'hec, 1'b0);
		$display("test temp done");
		otp[73] = 8'h00;
		rst_load;
		t_load(8'h0c, 8'h80, 8'h00);
		report_and_stop;
	end
endmodule
